// >>> logic/blpc_defines.svh
// constants for the boot loader and low power controller
`ifndef BLPC_DEFINES_SVH
`define BLPC_DEFINES_SVH
`define BLPC_CLK_HZ 100000000
`define BLPC_BAUD_RATE 9600
`define BLPC_DIV_FAST 6'd2
`define BLPC_DIV_SLOW 6'd32
`define BLPC_PIN_HOLD 5'd30
`define BLPC_SETTLE_SHORT 12'd16
`define BLPC_SETTLE_LONG 12'd4064
`define BLPC_LOAD_BASE 16'h0050
`define BLPC_PROG_START 16'h0051
`define BLPC_JUMP_KEY 8'hCC
`define BLPC_VEC_EXT 16'h1FFA
`define BLPC_VEC_RST 16'h1FFE
`define BLPC_SECURITY_OFF 1'b1
`define BLPC_REG_CTRL 8'h00
`define BLPC_REG_STAT 8'h04
`define BLPC_REG_COUNT 8'h08
`define BLPC_REG_LEN 8'h0C
`define BLPC_CTRL_SLOW 0
`define BLPC_CTRL_EXTEN 1
`define BLPC_CTRL_IMASK 2
`define BLPC_CTRL_RESET 8'h00
`endif

// >>> logic/blpc_pkg.sv
// types for the boot loader and low power controller
package blpc_pkg;
    typedef enum logic [2:0] {
        BLPC_SETTLE = 3'b000,
        BLPC_HOLD = 3'b001,
        BLPC_LOAD = 3'b010,
        BLPC_RUN = 3'b011,
        BLPC_STOP = 3'b100,
        BLPC_WAIT = 3'b101
    } blpc_state_e;
    typedef enum logic [1:0] {
        BLPC_NORMAL = 2'b00,
        BLPC_CHECK = 2'b01,
        BLPC_LOADER = 2'b10,
        BLPC_JUMP = 2'b11
    } blpc_boot_e;
    typedef struct packed {
        logic wdog_clear;
        logic eeprom_ro;
        logic serial_halt;
        logic timer_halt;
        logic pulse_hold;
        logic adc_off;
    } blpc_halt_s;
    typedef struct packed {
        logic ext;
        logic timer;
        logic serial;
    } blpc_wake_s;
endpackage : blpc_pkg

// >>> logic/blpc_ctrl.sv
// boot mode selection, serial loader and stop/wait power control
// Notes on behaviour
// - loader only when security bit reads one
// - bytes stored consecutively from 0050
// - first byte counts program plus itself
// - run loaded program at 0051
// - serial frame 8N1 at 9600 baud
// - short data waits; reset keeps RAM
// - jump needs CC, target on B:C
// - stop turns oscillator off, halts all
// - stop woken only by request, reset
// - stop entry clears mask, slow bit
// - stop keeps all other state unchanged
// - stop wake vectors 1FFA or 1FFE
// - settle delay 16 or 4064 cycles
// - stacking after stop or wait left
// - stop: watchdog reset, modules frozen
// - wait suspends cpu, peripherals keep running
// - wait clears mask, keeps request enable
// - wait woken by request, timer, serial
// - non-reset wait exit keeps state
// - wait stacking at moment of exit
// - slow bit cleared on reset, divides
`timescale 1ns/100ps
`include "blpc_defines.svh"

module blpc_ctrl
    import blpc_pkg::*;
#(
    parameter logic [11:0] SETTLE_CYCLES = `BLPC_SETTLE_LONG,
    parameter int BAUD_DIV = `BLPC_CLK_HZ / `BLPC_BAUD_RATE,
    parameter bit WAIT_WDOG_OFF = 1'b1
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // straps; mode pins read at end of pin hold, the rest sampled on the first clock after reset is released
    input wire logic hv_detect,
    input wire logic capture_input_one,
    input wire logic mode_select_pin_a,
    input wire logic mode_select_pin_b,
    input wire logic security_option_bit,
    // parallel ports for jump mode
    input wire logic [7:0] port_a,
    input wire logic [7:0] port_b,
    input wire logic [7:0] port_c,
    // serial receive line
    input wire logic serial_rx,
    // ram write port
    output logic ram_we,
    output logic [15:0] ram_addr,
    output logic [7:0] ram_wdata,
    // processor side
    input wire logic stop_req,
    input wire logic wait_req,
    input wire blpc_wake_s wake,
    output logic start_valid,
    output logic [15:0] start_addr,
    output logic stack_req,
    output logic cpu_hold,
    output logic osc_enable,
    output logic bus_tick,
    output blpc_halt_s halt,
    output logic slow_clock_select_bit,
    output logic external_request_enable_bit,
    output logic imask
);

    localparam logic [15:0] BAUD_FULL = 16'(BAUD_DIV - 1);
    localparam logic [15:0] BAUD_HALF = 16'(BAUD_DIV / 2);

    blpc_state_e state;
    blpc_boot_e boot_mode;
    logic [5:0] div_cnt, div_limit;
    logic [11:0] settle_cnt;
    logic [4:0] hold_cnt;
    logic from_reset, released, strap_boot, strap_secure;
    logic rx_prev, rx_busy, byte_valid;
    logic [15:0] baud_cnt;
    logic [3:0] bit_idx;
    logic [7:0] rx_shift, byte_data, load_len, load_idx;
    logic wake_stop, wake_wait, ctrl_wr;

    assign ctrl_wr = reg_wr && (reg_addr == `BLPC_REG_CTRL);
    assign wake_stop = wake.ext && external_request_enable_bit;
    assign wake_wait = wake_stop || wake.timer || wake.serial;

    assign div_limit = slow_clock_select_bit ? `BLPC_DIV_SLOW
                                             : `BLPC_DIV_FAST;

    always_ff @(posedge core_clk)
    begin
        if (reset || state == BLPC_STOP)
        begin
            div_cnt <= 6'h00;
            bus_tick <= 1'b0;
        end
        else if (div_cnt >= div_limit - 6'h01)
        begin
            div_cnt <= 6'h00;
            bus_tick <= 1'b1;
        end
        else
        begin
            div_cnt <= div_cnt + 6'h01;
            bus_tick <= 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            released <= 1'b0;
            strap_boot <= 1'b0;
            strap_secure <= 1'b0;
        end
        else if (!released)
        begin
            released <= 1'b1;
            strap_boot <= hv_detect && capture_input_one;
            strap_secure <= security_option_bit;
        end
    end

    // control register; hardware clear on stop entry takes priority
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            slow_clock_select_bit <= 1'b0;
            external_request_enable_bit <= 1'b0;
            imask <= 1'b1;
        end
        else if (state == BLPC_RUN && stop_req)
        begin
            slow_clock_select_bit <= 1'b0;
            imask <= 1'b0;
        end
        else if (state == BLPC_RUN && wait_req)
        begin
            imask <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            slow_clock_select_bit <= reg_wdata[`BLPC_CTRL_SLOW];
            external_request_enable_bit <= reg_wdata[`BLPC_CTRL_EXTEN];
            imask <= reg_wdata[`BLPC_CTRL_IMASK];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset || state != BLPC_LOAD)
        begin
            rx_prev <= 1'b1;
            rx_busy <= 1'b0;
            baud_cnt <= 16'h0000;
            bit_idx <= 4'h0;
            rx_shift <= 8'h00;
            byte_valid <= 1'b0;
            byte_data <= 8'h00;
        end
        else
        begin
            rx_prev <= serial_rx;
            byte_valid <= 1'b0;
            if (!rx_busy)
            begin
                if (rx_prev && !serial_rx)
                begin
                    rx_busy <= 1'b1;
                    baud_cnt <= BAUD_HALF;
                    bit_idx <= 4'h0;
                end
            end
            else if (baud_cnt != 16'h0000)
                baud_cnt <= baud_cnt - 16'h0001;
            else
            begin
                baud_cnt <= BAUD_FULL;
                bit_idx <= bit_idx + 4'h1;
                if (bit_idx == 4'h0 && serial_rx)
                    rx_busy <= 1'b0;
                else if (bit_idx >= 4'h1 && bit_idx <= 4'h8)
                    rx_shift <= {serial_rx, rx_shift[7:1]};
                else if (bit_idx == 4'h9)
                begin
                    // framing error drops the byte
                    rx_busy <= 1'b0;
                    byte_valid <= serial_rx;
                    byte_data <= rx_shift;
                end
            end
        end
    end

    // main sequencer
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            state <= BLPC_SETTLE;
            from_reset <= 1'b1;
            boot_mode <= BLPC_NORMAL;
            settle_cnt <= 12'h000;
            hold_cnt <= 5'h00;
            load_len <= 8'h00;
            load_idx <= 8'h00;
            start_valid <= 1'b0;
            start_addr <= 16'h0000;
            stack_req <= 1'b0;
            ram_we <= 1'b0;
            ram_addr <= 16'h0000;
            ram_wdata <= 8'h00;
        end
        else
        begin
            start_valid <= 1'b0;
            stack_req <= 1'b0;
            ram_we <= 1'b0;
            unique case (state)
                BLPC_SETTLE:
                begin
                    if (bus_tick)
                    begin
                        if (settle_cnt >= SETTLE_CYCLES - 12'h001)
                        begin
                            settle_cnt <= 12'h000;
                            hold_cnt <= 5'h00;
                            if (from_reset)
                                state <= BLPC_HOLD;
                            else
                            begin
                                state <= BLPC_RUN;
                                stack_req <= 1'b1;
                                start_valid <= 1'b1;
                                start_addr <= `BLPC_VEC_EXT;
                            end
                        end
                        else
                            settle_cnt <= settle_cnt + 12'h001;
                    end
                end
                BLPC_HOLD:
                begin
                    if (bus_tick && hold_cnt < `BLPC_PIN_HOLD - 5'h01)
                        hold_cnt <= hold_cnt + 5'h01;
                    else if (bus_tick)
                    begin
                        from_reset <= 1'b0;
                        state <= BLPC_RUN;
                        start_valid <= 1'b1;
                        start_addr <= `BLPC_VEC_RST;
                        if (!strap_boot)
                            boot_mode <= BLPC_NORMAL;
                        else if (!mode_select_pin_a)
                            boot_mode <= BLPC_CHECK;
                        else if (!mode_select_pin_b)
                        begin
                            boot_mode <= BLPC_LOADER;
                            if (strap_secure == `BLPC_SECURITY_OFF)
                            begin
                                state <= BLPC_LOAD;
                                start_valid <= 1'b0;
                                load_idx <= 8'h00;
                            end
                        end
                        else
                        begin
                            boot_mode <= BLPC_JUMP;
                            // key on A, target on B:C
                            if (port_a == `BLPC_JUMP_KEY)
                                start_addr <= {port_b, port_c};
                        end
                    end
                end
                BLPC_LOAD:
                begin
                    // short data waits; ram untouched by reset
                    if (byte_valid)
                    begin
                        ram_we <= 1'b1;
                        ram_addr <= `BLPC_LOAD_BASE + {8'h00, load_idx};
                        ram_wdata <= byte_data;
                        load_idx <= load_idx + 8'h01;
                        if (load_idx == 8'h00)
                            load_len <= byte_data;
                        if ((load_idx == 8'h00 && byte_data <= 8'h01) ||
                            (load_idx != 8'h00 &&
                             load_idx + 8'h01 == load_len))
                        begin
                            state <= BLPC_RUN;
                            start_valid <= 1'b1;
                            start_addr <= `BLPC_PROG_START;
                        end
                    end
                end
                BLPC_RUN:
                begin
                    if (stop_req)
                        state <= BLPC_STOP;
                    else if (wait_req)
                        state <= BLPC_WAIT;
                end
                BLPC_STOP:
                begin
                    if (wake_stop)
                    begin
                        state <= BLPC_SETTLE;
                        settle_cnt <= 12'h000;
                    end
                end
                BLPC_WAIT:
                begin
                    if (wake_wait)
                    begin
                        // other state left as it was
                        state <= BLPC_RUN;
                        stack_req <= 1'b1;
                    end
                end
                default:
                    state <= BLPC_SETTLE;
            endcase
        end
    end

    // power outputs follow the next state to stay registered
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            cpu_hold <= 1'b1;
            osc_enable <= 1'b1;
            halt <= '0;
        end
        else
        begin
            cpu_hold <= 1'b1;
            osc_enable <= 1'b1;
            halt <= '0;
            if (state == BLPC_RUN && !stop_req && !wait_req)
                cpu_hold <= 1'b0;
            else if (state == BLPC_WAIT && wake_wait)
                cpu_hold <= 1'b0;
            if ((state == BLPC_RUN && stop_req) ||
                (state == BLPC_STOP && !wake_stop))
            begin
                osc_enable <= 1'b0;
                halt <= '{wdog_clear: 1'b1, eeprom_ro: 1'b1,
                          serial_halt: 1'b1, timer_halt: 1'b1,
                          pulse_hold: 1'b1, adc_off: 1'b1};
            end
            else if ((state == BLPC_RUN && wait_req) ||
                     (state == BLPC_WAIT && !wake_wait))
                halt.wdog_clear <= WAIT_WDOG_OFF;
        end
    end

    // register reads, data one cycle after strobe
    always_ff @(posedge core_clk)
    begin
        if (reset)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                `BLPC_REG_CTRL:
                    reg_rdata <= {5'h00, imask,
                                  external_request_enable_bit,
                                  slow_clock_select_bit};
                `BLPC_REG_STAT:
                    reg_rdata <= {2'h0, strap_secure, boot_mode, state};
                `BLPC_REG_COUNT:
                    reg_rdata <= load_idx;
                `BLPC_REG_LEN:
                    reg_rdata <= load_len;
                default:
                    reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

endmodule : blpc_ctrl

// >>> verification/blpc_host_model.sv
// host model sending bytes on the serial receive line
`timescale 1ns/100ps
module blpc_host_model #(
    parameter int BIT_CYCLES = 8
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // byte request
    input wire logic send,
    input wire logic [7:0] tx_byte,
    output logic busy,
    // line with pull-up
    output logic serial_rx
);
    logic [9:0] frame;
    int bit_idx, cyc_idx;
    // idle high, start, eight data lsb first, stop
    assign serial_rx = busy ? frame[bit_idx] : 1'b1;
    always_ff @(posedge core_clk)
    begin
        if (reset || (!busy && send))
        begin
            busy <= !reset;
            frame <= {1'b1, tx_byte, 1'b0};
            bit_idx <= 0;
            cyc_idx <= 0;
        end
        else if (busy && cyc_idx == BIT_CYCLES - 1)
        begin
            cyc_idx <= 0;
            bit_idx <= bit_idx + 1;
            busy <= (bit_idx != 9);
        end
        else if (busy)
            cyc_idx <= cyc_idx + 1;
    end
endmodule : blpc_host_model

// >>> verification/blpc_ctrl_assertions.sv
// port assertions for the boot and power controller
`timescale 1ns/100ps
module blpc_ctrl_assertions
    import blpc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // ram write port
    input wire logic ram_we,
    input wire logic [15:0] ram_addr,
    // processor side
    input wire blpc_wake_s wake,
    input wire logic start_valid,
    input wire logic [15:0] start_addr,
    input wire logic stack_req,
    input wire logic osc_enable,
    input wire logic bus_tick,
    input wire blpc_halt_s halt,
    input wire logic slow_clock_select_bit,
    input wire logic external_request_enable_bit,
    input wire logic imask
);
    logic [15:0] last_addr;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    // no reset: a new load always restarts at the base address
    always_ff @(posedge core_clk)
    begin
        if (ram_we)
            last_addr <= ram_addr;
    end
    a_stop_clears_bits: assert property ($fell(osc_enable) |->
        !slow_clock_select_bit && !imask) else $error("stop kept bits");
    a_stop_halts_all: assert property (!osc_enable |-> halt == 6'h3F)
        else $error("stop not halting");
    a_stop_no_tick: assert property (!osc_enable && !$past(osc_enable)
        |-> !bus_tick) else $error("tick while stopped");
    a_stop_wake_cause: assert property ($rose(osc_enable) |->
        $past(wake.ext) && $past(external_request_enable_bit))
        else $error("stop left without request");
    a_wake_vector: assert property (start_valid && stack_req |->
        start_addr == 16'h1FFA) else $error("bad wake vector");
    a_stack_running: assert property (stack_req |-> osc_enable)
        else $error("stacking while stopped");
    a_load_order: assert property (ram_we && ram_addr != 16'h0050 |->
        ram_addr == last_addr + 16'h0001) else $error("load out of order");
    a_run_loaded: assert property (start_valid && start_addr == 16'h0051
        |-> ram_we) else $error("run before load done");
    c_loader_run: cover property (start_valid && start_addr == 16'h0051);
    c_stop_entry: cover property ($fell(osc_enable));
    c_wait_wake: cover property (stack_req && !start_valid);
endmodule : blpc_ctrl_assertions

bind blpc_ctrl blpc_ctrl_assertions blpc_ctrl_assertions_inst (
    .core_clk, .reset, .ram_we, .ram_addr, .wake, .start_valid,
    .start_addr, .stack_req, .osc_enable, .bus_tick, .halt,
    .slow_clock_select_bit, .external_request_enable_bit, .imask);

// >>> verification/tb.sv
// self-checking bench for the boot and power controller
`timescale 1ns/100ps
module tb;
    import blpc_pkg::*;
    localparam int SETTLE = 16;
    localparam int BOOT = 2 * (SETTLE + 30);
    logic core_clk, reset, reg_wr, reg_rd, hv_detect, capture_input_one;
    logic mode_select_pin_a, mode_select_pin_b, security_option_bit;
    logic serial_rx, ram_we, stop_req, wait_req, start_valid, stack_req;
    logic cpu_hold, osc_enable, bus_tick, slow_clock_select_bit, imask;
    logic external_request_enable_bit, send, busy;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, port_a, port_b, port_c;
    logic [7:0] ram_wdata, tx_byte, rd;
    logic [15:0] ram_addr, start_addr, ex;
    blpc_wake_s wake;
    blpc_halt_s halt;
    int error_cnt, cmp_count, cyc, t0, n, stk_cnt, tick_cnt;
    logic [7:0] bytes[$], got_d[$];
    logic [15:0] got_a[$], st_a[$];
    int st_c[$];
    logic st_s[$];

    blpc_ctrl #(.SETTLE_CYCLES(12'(SETTLE)), .BAUD_DIV(8)) blpc_ctrl_inst (
        .core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .hv_detect, .capture_input_one, .mode_select_pin_a,
        .mode_select_pin_b, .security_option_bit, .port_a, .port_b, .port_c,
        .serial_rx, .ram_we, .ram_addr, .ram_wdata, .stop_req, .wait_req,
        .wake, .start_valid, .start_addr, .stack_req, .cpu_hold, .osc_enable,
        .bus_tick, .halt, .slow_clock_select_bit,
        .external_request_enable_bit, .imask);
    blpc_host_model #(.BIT_CYCLES(8)) blpc_host_model_inst (
        .core_clk, .reset, .send, .tx_byte, .busy, .serial_rx);

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            error_cnt++;
            $display("mismatch at %0t: run timed out", $time);
            finish_test;
        end
    end
    // collect pulses off the active edge
    always @(negedge core_clk)
    begin
        if (ram_we === 1'b1)
        begin
            got_a.push_back(ram_addr);
            got_d.push_back(ram_wdata);
        end
        if (start_valid === 1'b1)
        begin
            st_a.push_back(start_addr);
            st_c.push_back(cyc - t0);
            st_s.push_back(stack_req);
        end
        stk_cnt += int'(stack_req === 1'b1);
        tick_cnt += int'(bus_tick === 1'b1);
    end

    task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask : chk
    task reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task reg_read(input logic [7:0] a);
        @(posedge core_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask : reg_read
    task wait_state(input logic [2:0] s);
        rd = 8'hFF;
        for (int w = 0; w < 100 && rd[2:0] !== s; w++)
            reg_read(8'h04);
        chk(16'(rd[2:0]), 16'(s), "state");
    endtask : wait_state
    task boot(input logic strap, input logic a, input logic b, input logic s);
        reset <= 1'b1;
        {hv_detect, capture_input_one} <= {strap, strap};
        {mode_select_pin_a, mode_select_pin_b} <= {a, b};
        security_option_bit <= s;
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        t0 = cyc;
    endtask : boot
    task wait_start(input logic [15:0] e, input int lo, hi, input logic k);
        for (int w = 0; w < 20000 && st_a.size() == 0; w++)
            @(posedge core_clk);
        @(negedge core_clk);
        chk(16'(st_a.size()), 16'h1, "start pulses");
        if (st_a.size() != 0)
        begin
            chk(st_a[0], e, "start address");
            chk(16'(st_s[0]), 16'(k), "stack request");
            chk(16'(st_c[0] >= lo && st_c[0] <= hi), 16'h1, "start delay");
        end
        st_a.delete();
        st_c.delete();
        st_s.delete();
    endtask : wait_start
    task send_byte(input logic [7:0] b);
        @(posedge core_clk);
        {send, tx_byte} <= {1'b1, b};
        @(posedge core_clk);
        send <= 1'b0;
        @(negedge busy);
    endtask : send_byte
    task pulse_req(input logic stop);
        @(posedge core_clk);
        {stop_req, wait_req} <= {stop, !stop};
        @(posedge core_clk);
        {stop_req, wait_req} <= 2'b00;
        @(posedge core_clk);
        #1;
    endtask : pulse_req
    task tick_rate(input int per);
        repeat (32) @(posedge core_clk);
        n = tick_cnt;
        repeat (64) @(posedge core_clk);
        chk(16'(tick_cnt - n), 16'(64 / per), "tick rate");
    endtask : tick_rate
    task finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test

    initial
    begin
        {reg_wr, reg_rd, stop_req, wait_req, send} = 5'h00;
        {reg_addr, reg_wdata, port_a, port_b, port_c, tx_byte} = 48'h0;
        wake = '0;
        void'($urandom(32'hBB861B55));
        boot(1'b0, 1'b0, 1'b0, 1'b1);
        wait_start(16'h1FFE, BOOT - 2, BOOT + 8, 1'b0);
        reg_read(8'h00);
        chk({8'h00, rd}, 16'h0004, "ctrl after reset");
        reg_read(8'h10);
        chk({8'h00, rd}, 16'h0000, "unmapped read");
        tick_rate(2);
        reg_write(8'h00, 8'h01);
        tick_rate(32);
        $display("test boot and rate done");
        reg_write(8'h00, 8'h07);
        pulse_req(1'b1);
        chk(16'({osc_enable, slow_clock_select_bit, imask}), 16'h0, "stop");
        chk(16'(halt), 16'h003F, "stop halt");
        wake <= 3'b011;
        repeat (40) @(posedge core_clk);
        chk(16'({osc_enable, cpu_hold}), 16'h1, "woken by other");
        t0 = cyc;
        wake <= 3'b100;
        wait_start(16'h1FFA, 2 * SETTLE, 2 * SETTLE + 8, 1'b1);
        wake <= 3'b000;
        wait_state(3'd3);
        reg_read(8'h00);
        chk({8'h00, rd & 8'h03}, 16'h0002, "stop kept enable");
        $display("test stop done");
        for (int i = 0; i < 3; i++)
        begin
            reg_write(8'h00, 8'h06);
            pulse_req(1'b0);
            chk(16'({cpu_hold, imask, halt}), 16'h00A0, "wait");
            reg_read(8'h00);
            chk(16'(rd[2:1]), 16'h0001, "wait mask and enable");
            n = stk_cnt;
            wake <= blpc_wake_s'(3'b100 >> i);
            wait_state(3'd3);
            wake <= 3'b000;
            chk(16'(stk_cnt - n), 16'h1, "wait stacking");
            chk(16'(st_a.size()), 16'h0, "wait vector");
        end
        $display("test wait done");
        pulse_req(1'b1);
        boot(1'b0, 1'b0, 1'b0, 1'b1);
        wait_start(16'h1FFE, BOOT - 2, BOOT + 8, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            port_a <= (i == 3) ? 8'h33 : 8'hCC;
            {port_b, port_c} <= 16'($urandom);
            boot(1'b1, 1'b1, 1'b1, 1'b1);
            ex = (i == 3) ? 16'h1FFE : {port_b, port_c};
            wait_start(ex, BOOT - 2, BOOT + 8, 1'b0);
        end
        boot(1'b1, 1'b1, 1'b0, 1'b0);
        wait_start(16'h1FFE, BOOT - 2, BOOT + 8, 1'b0);
        boot(1'b1, 1'b0, 1'b1, 1'b1);
        wait_start(16'h1FFE, BOOT - 2, BOOT + 8, 1'b0);
        reg_read(8'h04);
        chk({8'h00, rd}, 16'h002B, "check mode status");
        $display("test jump done");
        boot(1'b1, 1'b1, 1'b0, 1'b1);
        wait_state(3'd2);
        got_a.delete();
        bytes = {8'h05};
        repeat (4) bytes.push_back(8'($urandom));
        foreach (bytes[i]) send_byte(bytes[i]);
        wait_start(16'h0051, 0, 30000, 1'b0);
        chk(16'(got_a.size()), 16'd5, "stored count");
        foreach (got_a[i])
        begin
            chk(got_a[i], 16'h0050 + 16'(i), "ram address");
            chk({8'h00, got_d[i]}, {8'h00, bytes[i]}, "ram data");
        end
        reg_read(8'h08);
        chk({8'h00, rd}, 16'd5, "byte count");
        reg_read(8'h0C);
        chk({8'h00, rd}, {8'h00, bytes[0]}, "length byte");
        boot(1'b1, 1'b1, 1'b0, 1'b1);
        wait_state(3'd2);
        send_byte(8'h09);
        send_byte(8'hA5);
        repeat (200) @(posedge core_clk);
        wait_state(3'd2);
        n = got_a.size();
        boot(1'b0, 1'b0, 1'b0, 1'b1);
        wait_start(16'h1FFE, BOOT - 2, BOOT + 8, 1'b0);
        chk(16'(got_a.size() - n), 16'h0, "ram kept over reset");
        $display("test loader done");
        finish_test;
    end
endmodule : tb
